// ===== agpc_consts.svh
// constants for the amplifier gain and power control block
// assumes inclusion by bare name from the package and the top module
`ifndef AGPC_CONSTS_SVH
`define AGPC_CONSTS_SVH

// serial register addresses
`define AGPC_REG_REV      2'h0
`define AGPC_REG_PROD     2'h1
`define AGPC_REG_PWR      2'h2
`define AGPC_REG_ATTEN    2'h3

// reset values of the writable registers
`define AGPC_PWR_RST      8'h00
`define AGPC_ATTEN_RST    8'h50

// identity codes, values arbitrary
`define AGPC_REV_CODE     8'h5a
`define AGPC_PROD_CODE    8'h3c

// power register: both off bits high turn the amplifier off
`define AGPC_PWR_OFF_A    2
`define AGPC_PWR_OFF_B    1

// frame layout, bit positions in the 16-bit shift register
`define AGPC_RW_BIT       15
`define AGPC_ADDR_HI      9
`define AGPC_ADDR_LO      8

// frame bit counts
`define AGPC_BYTE_LAST    5'h07
`define AGPC_BYTE_LEN     5'h08
`define AGPC_FRAME_LEN    5'h10
`define AGPC_FRAME_OVER   5'h11

// parallel code clamp, codes above give minimum gain
`define AGPC_PAR_CODE_MAX 4'ha

// synchroniser depth for pins from outside the clock domain
`define AGPC_SYNC_STAGES  2

`endif

// ===== agpc_pkg.sv
// types shared by the amplifier gain and power control block
// assumes the constants header sits in the same folder
package agpc_pkg;
`include "agpc_consts.svh"

   // serial frame sequencer states
   typedef enum logic [0:0]
   {
      AGPC_ST_IDLE  = 1'b0,
      AGPC_ST_FRAME = 1'b1
   } agpc_state_t;

   // raw pin group, also the synchronised copy
   typedef struct packed
   {
      logic mode_serial; // high selects serial control
      logic shutdown;    // amp_shutdown_pin
      logic cs_n;        // chip select, active low
      logic pin15;       // gain_bit_2 or serial clock
      logic pin3;        // gain_bit_1 or serial data in
      logic pin4;        // gain_bit_0 or serial data out readback
      logic gain3;       // gain_bit_3
   } agpc_pins_t;

   // whole state of the top module
   typedef struct packed
   {
      agpc_state_t state;     // frame sequencer
      logic        sclk_prev; // last sampled serial clock
      logic [4:0]  cnt;       // rising edges seen in the frame
      logic [15:0] shift;     // shifted-in frame bits
      logic [7:0]  rd_byte;   // register value to send out
      logic        sdo;       // serial output bit
      logic        sdo_oe;    // serial output drive
      logic [7:0]  pwr;       // amp_power_control
      logic [7:0]  atten;     // gain_attenuation
      logic [6:0]  out_atten; // applied attenuation, quarter dB
      logic        out_off;   // applied amplifier off
      logic        out_serial;// applied control mode
   } agpc_regs_t;

endpackage

// ===== agpc_sync.sv
// two-flop synchroniser for a group of pins
// assumes inputs asynchronous to i_sys_clk
`timescale 1ns/1ps
module agpc_sync
#(
   parameter int W = 1
)
(
   input  wire logic         i_sys_clk,
   input  wire logic         i_rst_n,
   input  wire logic [W-1:0] i_async,
   output logic      [W-1:0] o_sync
);

   // first stage feeds only the second stage
   typedef struct packed
   {
      logic [W-1:0] meta;
      logic [W-1:0] sync;
   } agpc_sync_st_t;

   agpc_sync_st_t st_q;
   agpc_sync_st_t st_d;

   // next state: shift one stage per clock
   always_comb
   begin
      st_d      = st_q;
      st_d.meta = i_async;
      st_d.sync = st_q.meta;
   end

   // register with synchronous reset to zero
   always_ff @(posedge i_sys_clk)
   begin
      if (!i_rst_n)
      begin
         st_q <= '0;
      end
      else
      begin
         st_q <= st_d;
      end
   end

   assign o_sync = st_q.sync;

endmodule

// ===== agpc_top.sv
// gain and power control logic of a programmable differential amplifier
// assumes pin levels from the bench, serial clock slower than i_sys_clk
`timescale 1ns/1ps
`include "agpc_consts.svh"
module agpc_top
   import agpc_pkg::*;
#(
   parameter logic [7:0] REV_CODE  = `AGPC_REV_CODE,  // arbitrary value
   parameter logic [7:0] PROD_CODE = `AGPC_PROD_CODE  // arbitrary value
)
(
   input  wire logic       i_sys_clk,
   input  wire logic       i_rst_n,
   input  wire logic       i_mode_serial,
   input  wire logic       i_amp_shutdown_pin,
   input  wire logic       i_cs_n,
   input  wire logic       i_pin3,
   input  wire logic       i_pin4,
   input  wire logic       i_pin15,
   input  wire logic       i_gain_bit_3,
   output logic            o_pin4,
   output logic            o_pin4_oe,
   output logic      [6:0] o_atten_qdb,
   output logic            o_amp_off,
   output logic            o_serial_mode
);

   // parallel code to attenuation in quarter dB, clamped at code 10
   function automatic logic [6:0] agpc_par_atten(input logic [3:0] code);
      logic [3:0] c;
      c = (code > `AGPC_PAR_CODE_MAX) ? `AGPC_PAR_CODE_MAX : code;
      agpc_par_atten = {c, 3'h0};
   endfunction

   // read decode of the four serial registers
   function automatic logic [7:0] agpc_read_reg(input logic [1:0] addr,
                                                input logic [7:0] pwr,
                                                input logic [7:0] atten);
      case (addr)
         `AGPC_REG_REV:  agpc_read_reg = REV_CODE;
         `AGPC_REG_PROD: agpc_read_reg = PROD_CODE;
         `AGPC_REG_PWR:  agpc_read_reg = pwr;
         default:        agpc_read_reg = atten;
      endcase
   endfunction

   agpc_pins_t pins_raw;  // pins as they arrive
   agpc_pins_t pins_s;    // pins after two flops
   agpc_regs_t q;         // registered state
   agpc_regs_t d;         // next state
   logic       sclk_rise; // serial clock rising edge seen
   logic       sclk_fall; // serial clock falling edge seen
   logic [3:0] par_code;  // parallel gain code
   logic       frame_ok;  // frame ended after exactly 16 clocks
   logic [1:0] frame_addr;// address field of the ended frame
   logic       frame_wr;  // ended frame is a write

   // gather pins into one group for the synchroniser
   always_comb
   begin
      pins_raw.mode_serial = i_mode_serial;
      pins_raw.shutdown    = i_amp_shutdown_pin;
      pins_raw.cs_n        = i_cs_n;
      pins_raw.pin15       = i_pin15;
      pins_raw.pin3        = i_pin3;
      pins_raw.pin4        = i_pin4;
      pins_raw.gain3       = i_gain_bit_3;
   end

   // every pin crosses two flops before any logic looks at it
   agpc_sync #(
      .W ($bits(agpc_pins_t))
   ) u_sync (
      .i_sys_clk (i_sys_clk),
      .i_rst_n   (i_rst_n),
      .i_async   (pins_raw),
      .o_sync    (pins_s)
   );

   // edge finder on the synchronised serial clock
   // a clock held low between frames just shows no edges
   assign sclk_rise = pins_s.pin15 & ~q.sclk_prev;
   assign sclk_fall = ~pins_s.pin15 & q.sclk_prev;

   // shared pins read as gain bits 3..0 in parallel mode
   assign par_code = {pins_s.gain3, pins_s.pin15, pins_s.pin3, pins_s.pin4};

   // end-of-frame decode
   assign frame_ok   = (q.cnt == `AGPC_FRAME_LEN);
   assign frame_addr = q.shift[`AGPC_ADDR_HI:`AGPC_ADDR_LO];
   assign frame_wr   = ~q.shift[`AGPC_RW_BIT];

   // next-state logic for sequencer, registers and outputs
   always_comb
   begin
      d           = q;
      d.sclk_prev = pins_s.pin15;
      if (!pins_s.mode_serial)
      begin
         // parallel mode: serial slave held idle
         d.state = AGPC_ST_IDLE;
         d.sdo   = 1'b0;
      end
      else
      begin
         case (q.state)
            AGPC_ST_IDLE:
            begin
               // chip select low opens a fresh access
               if (!pins_s.cs_n)
               begin
                  d.state = AGPC_ST_FRAME;
                  d.cnt   = 5'h00;
                  d.sdo   = 1'b0;
               end
            end
            AGPC_ST_FRAME:
            begin
               if (pins_s.cs_n)
               begin
                  // chip select rise: write only on a full frame
                  d.state = AGPC_ST_IDLE;
                  d.sdo   = 1'b0;
                  if (frame_ok && frame_wr)
                  begin
                     // identity registers ignore writes
                     if (frame_addr == `AGPC_REG_PWR)
                     begin
                        d.pwr = q.shift[7:0];
                     end
                     else if (frame_addr == `AGPC_REG_ATTEN)
                     begin
                        d.atten = q.shift[7:0];
                     end
                  end
               end
               else
               begin
                  // rising edge: sample data in, msb first
                  if (sclk_rise)
                  begin
                     d.shift = {q.shift[14:0], pins_s.pin3};
                     if (q.cnt != `AGPC_FRAME_OVER)
                     begin
                        d.cnt = q.cnt + 5'h01;
                     end
                     // first byte done: fetch the addressed register
                     if (q.cnt == `AGPC_BYTE_LAST)
                     begin
                        d.rd_byte = agpc_read_reg({q.shift[0], pins_s.pin3},
                                                  q.pwr, q.atten);
                     end
                  end
                  // falling edge: drive the read byte, msb first
                  if (sclk_fall && (q.cnt >= `AGPC_BYTE_LEN)
                      && (q.cnt < `AGPC_FRAME_LEN))
                  begin
                     d.sdo = q.rd_byte[~q.cnt[2:0]];
                  end
               end
            end
            default:
            begin
               d.state = AGPC_ST_IDLE;
            end
         endcase
      end
      // output sources for a one, switches off for a zero
      d.sdo_oe = pins_s.mode_serial && (d.state == AGPC_ST_FRAME)
                 && !pins_s.cs_n && d.sdo;
      // applied gain and power, chosen by the mode pin
      d.out_serial = pins_s.mode_serial;
      if (pins_s.mode_serial)
      begin
         d.out_atten = d.atten[6:0];
         d.out_off   = d.pwr[`AGPC_PWR_OFF_A] & d.pwr[`AGPC_PWR_OFF_B];
      end
      else
      begin
         // direct from pins; idle bus code 14 clamps to minimum gain
         d.out_atten = agpc_par_atten(par_code);
         d.out_off   = pins_s.shutdown;
      end
   end

   // state register, synchronous reset
   always_ff @(posedge i_sys_clk)
   begin
      if (!i_rst_n)
      begin
         q           <= '0;
         q.state     <= AGPC_ST_IDLE;
         q.pwr       <= `AGPC_PWR_RST;
         q.atten     <= `AGPC_ATTEN_RST;
         q.out_atten <= agpc_par_atten(4'h0);
      end
      else
      begin
         q <= d;
      end
   end

   // outputs straight from flops
   assign o_pin4        = q.sdo;
   assign o_pin4_oe     = q.sdo_oe;
   assign o_atten_qdb   = q.out_atten;
   assign o_amp_off     = q.out_off;
   assign o_serial_mode = q.out_serial;

   // parallel code maps to attenuation one clock after the synchronised pins
   a_parallel_gain_map: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
      (!pins_s.mode_serial) |=> (o_atten_qdb == agpc_par_atten($past(par_code))))
      else $error("parallel gain mapping wrong");

   // shutdown pin follows in parallel mode, gain untouched
   a_parallel_shut: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
      (!pins_s.mode_serial) |=> (o_amp_off == $past(pins_s.shutdown)))
      else $error("shutdown pin not applied");

   // serial mode: power register alone decides off
   a_serial_off_src: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
      $past(pins_s.mode_serial) |-> (o_amp_off == (q.pwr[2] & q.pwr[1])))
      else $error("serial off not from power register");

   // no drive once chip select is high
   a_sdo_hiz_idle: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
      pins_s.cs_n |=> !o_pin4_oe)
      else $error("serial output driven without select");

   // short or long frames leave registers untouched
   a_bad_frame_nowr: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
      (q.state == AGPC_ST_FRAME && pins_s.cs_n && pins_s.mode_serial && !frame_ok)
      |=> ($stable(q.pwr) && $stable(q.atten)))
      else $error("register written by incomplete frame");

   // identity registers never change the writable ones
   a_ro_no_write: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
      (q.state == AGPC_ST_FRAME && pins_s.cs_n && frame_addr[1] == 1'b0)
      |=> ($stable(q.pwr) && $stable(q.atten)))
      else $error("write to identity register had effect");

   // full write frame lands in the attenuation register
   a_atten_write: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
      (q.state == AGPC_ST_FRAME && pins_s.cs_n && pins_s.mode_serial && frame_ok
       && frame_wr && frame_addr == `AGPC_REG_ATTEN)
      |=> (q.atten == $past(q.shift[7:0])) ##1 (o_atten_qdb == q.atten[6:0]))
      else $error("attenuation write lost");

   // data in sampled on the rising edge
   a_rise_sample: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
      (q.state == AGPC_ST_FRAME && !pins_s.cs_n && pins_s.mode_serial && sclk_rise)
      |=> (q.shift[0] == $past(pins_s.pin3)))
      else $error("data in not sampled on rise");

   // output bit changes only on a falling edge within a frame
   a_fall_only: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
      (q.state == AGPC_ST_FRAME && !pins_s.cs_n && pins_s.mode_serial && !sclk_fall)
      |=> $stable(q.sdo))
      else $error("serial output moved off a falling edge");

   // select low starts count from zero
   a_fresh_frame: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
      (q.state == AGPC_ST_IDLE && !pins_s.cs_n && pins_s.mode_serial)
      |=> (q.cnt == 5'h00 && q.state == AGPC_ST_FRAME))
      else $error("frame did not start fresh");

   // register reset values after release
   a_reset_values: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
      $past(!i_rst_n) |-> (q.pwr == `AGPC_PWR_RST && q.atten == `AGPC_ATTEN_RST))
      else $error("register reset values wrong");

   // main scenarios
   c_serial_write: cover property (@(posedge i_sys_clk) disable iff (!i_rst_n)
      q.state == AGPC_ST_FRAME && pins_s.cs_n && frame_ok && frame_wr);
   c_serial_read: cover property (@(posedge i_sys_clk) disable iff (!i_rst_n)
      q.state == AGPC_ST_FRAME && pins_s.cs_n && frame_ok && !frame_wr);
   c_short_frame: cover property (@(posedge i_sys_clk) disable iff (!i_rst_n)
      q.state == AGPC_ST_FRAME && pins_s.cs_n && !frame_ok);
   c_par_shutdown: cover property (@(posedge i_sys_clk) disable iff (!i_rst_n)
      !o_serial_mode && o_amp_off);

endmodule

// ===== agpc_host.sv
// host model: drives the parallel gain pins and the four-wire serial port
// assumes the bench resolves the shared data-out pin and hands its level in
`timescale 1ns/1ps
module agpc_host
(
   input  wire logic i_sys_clk,
   input  wire logic i_sdo,
   output logic      o_mode_serial,
   output logic      o_shutdown,
   output logic      o_cs_n,
   output logic      o_pin3,
   output logic      o_pin15,
   output logic      o_gain3,
   output logic      o_g0,
   output logic      o_g0_en
);
   // floating pins: mode pulled down, gain bits 3..1 up, bit 0 down
   initial
   begin
      o_mode_serial = 1'b0;
      o_shutdown    = 1'b0;
      o_cs_n        = 1'b1;
      o_pin3        = 1'b1;
      o_pin15       = 1'b1;
      o_gain3       = 1'b1;
      o_g0          = 1'b0;
      o_g0_en       = 1'b0;
   end

   // wait on falling system clock edges
   task automatic ticks(input int n);
      repeat (n) @(negedge i_sys_clk);
   endtask

   // parallel code and shutdown, all pins moved in one step
   task automatic set_par(input logic [3:0] code, input logic sd);
      ticks(1);
      o_mode_serial = 1'b0;
      {o_gain3, o_pin15, o_pin3, o_g0} = code;
      o_g0_en       = 1'b1;
      o_shutdown    = sd;
   endtask

   // serial mode, clock parked low, bit 0 driver released
   task automatic serial();
      ticks(1);
      o_mode_serial = 1'b1;
      o_g0_en       = 1'b0;
      o_pin15       = 1'b0;
      o_cs_n        = 1'b1;
   endtask

   // one framed access, msb first, read bits taken at rises 9..16
   task automatic frame(input logic [15:0] word, input int rises, output logic [7:0] rd);
      logic [15:0] w;
      w  = word;
      rd = 8'h00;
      ticks(1);
      o_cs_n = 1'b0;
      ticks(4);
      for (int i = 0; i < rises; i++)
      begin
         o_pin3 = w[15];
         w      = {w[14:0], 1'b0};
         ticks(4);
         if (i >= 8 && i < 16)
         begin
            rd = {rd[6:0], i_sdo};
         end
         o_pin15 = 1'b1;
         ticks(4);
         o_pin15 = 1'b0;
      end
      ticks(4);
      o_cs_n = 1'b1;
      o_pin3 = ~o_pin3;
      ticks(8);
   endtask
endmodule

// ===== agpc_top_test.sv
// self-checking bench for the gain and power control block
// assumes the host model drives every pin at the falling clock edge
`timescale 1ns/1ps
module agpc_top_test;
   localparam logic [7:0] REV  = 8'h33; // arbitrary value
   localparam logic [7:0] PROD = 8'h44; // arbitrary value

   logic       i_sys_clk;
   logic       i_rst_n;
   wire        mode, sd, cs_n, pin3, pin15, gain3, g0, g0_en;
   logic       o_pin4, o_pin4_oe, o_amp_off, o_serial_mode;
   logic [6:0] o_atten_qdb;
   wire        pin4_w;
   int         fail_count;
   int         n_checks;

   // shared pin: design sources a one, else host bit 0 or bias to ground
   assign pin4_w = o_pin4_oe ? o_pin4 : (g0_en & g0);

   initial i_sys_clk = 1'b0;
   always #20 i_sys_clk = ~i_sys_clk;

   agpc_host host (.i_sys_clk(i_sys_clk), .i_sdo(pin4_w), .o_mode_serial(mode),
      .o_shutdown(sd), .o_cs_n(cs_n), .o_pin3(pin3), .o_pin15(pin15),
      .o_gain3(gain3), .o_g0(g0), .o_g0_en(g0_en));

   agpc_top #(.REV_CODE(REV), .PROD_CODE(PROD)) DUT (.i_sys_clk(i_sys_clk),
      .i_rst_n(i_rst_n), .i_mode_serial(mode), .i_amp_shutdown_pin(sd),
      .i_cs_n(cs_n), .i_pin3(pin3), .i_pin4(pin4_w), .i_pin15(pin15),
      .i_gain_bit_3(gain3), .o_pin4(o_pin4), .o_pin4_oe(o_pin4_oe),
      .o_atten_qdb(o_atten_qdb), .o_amp_off(o_amp_off),
      .o_serial_mode(o_serial_mode));

   // compare and count
   task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string msg);
      n_checks++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("wrong value at %0t: %s got %h expected %h", $time, msg, seen, exp);
      end
   endtask

   // verdict and end of run
   task automatic results();
      if (fail_count == 0 && n_checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   // frame, then data-out must be released
   task automatic xfer(input logic [15:0] word, input int rises, output logic [7:0] rd);
      host.frame(word, rises, rd);
      check({7'h00, o_pin4_oe}, 8'h00, "data out drive");
   endtask

   // read one register and compare
   task automatic rd_chk(input logic [1:0] a, input logic [7:0] exp);
      logic [7:0] rd;
      xfer({6'h20, a, 8'h00}, 16, rd);
      check(rd, exp, "register read");
   endtask

   // write one register with a chosen number of rises
   task automatic wr(input logic [1:0] a, input logic [7:0] d, input int rises);
      logic [7:0] rd;
      xfer({6'h00, a, d}, rises, rd);
      host.ticks(6);
   endtask

   // reset values, then floating pins give minimum gain
   task automatic t_reset();
      i_rst_n = 1'b0;
      host.ticks(5);
      check({1'b0, o_atten_qdb}, 8'h00, "atten in reset");
      host.ticks(1);
      i_rst_n = 1'b1;
      host.ticks(6);
      check({1'b0, o_atten_qdb}, 8'h50, "floating gain");
      check({7'h00, o_serial_mode}, 8'h00, "mode floating");
   endtask

   // every parallel code, shutdown keeps the gain
   task automatic t_parallel();
      logic [7:0] e;
      for (int c = 0; c < 16; c++)
      begin
         e = (c > 10) ? 8'h50 : 8'(c * 8);
         host.set_par(4'(c), c[0]);
         host.ticks(5);
         check({1'b0, o_atten_qdb}, e, "parallel gain");
         check({7'h00, o_amp_off}, {7'h00, c[0]}, "shutdown pin");
      end
   endtask

   // serial mode: shutdown pin ignored, reset contents read back
   task automatic t_reads();
      host.serial();
      host.ticks(6);
      check({7'h00, o_serial_mode}, 8'h01, "serial mode");
      check({7'h00, o_amp_off}, 8'h00, "pin ignored");
      check({1'b0, o_atten_qdb}, 8'h50, "atten reset");
      rd_chk(2'h0, REV);
      rd_chk(2'h1, PROD);
      rd_chk(2'h2, 8'h00);
      rd_chk(2'h3, 8'h50);
   endtask

   // writes land, read-only places ignore them
   task automatic t_writes();
      wr(2'h3, 8'h20, 16);
      check({1'b0, o_atten_qdb}, 8'h20, "atten write");
      rd_chk(2'h3, 8'h20);
      wr(2'h0, 8'hff, 16);
      wr(2'h1, 8'h00, 16);
      rd_chk(2'h0, REV);
      rd_chk(2'h1, PROD);
   endtask

   // only both off bits set turn the amplifier off
   task automatic t_power();
      logic [7:0] v [5];
      logic [7:0] off [5];
      v   = '{8'h06, 8'h04, 8'h02, 8'hff, 8'h00};
      off = '{8'h01, 8'h00, 8'h00, 8'h01, 8'h00};
      for (int i = 0; i < 5; i++)
      begin
         wr(2'h2, v[i], 16);
         check({7'h00, o_amp_off}, off[i], "power off");
         rd_chk(2'h2, v[i]);
      end
   endtask

   // frames of 15 and 17 rises write nothing
   task automatic t_short();
      wr(2'h3, 8'h11, 15);
      check({1'b0, o_atten_qdb}, 8'h20, "short frame");
      wr(2'h3, 8'h11, 17);
      check({1'b0, o_atten_qdb}, 8'h20, "long frame");
      rd_chk(2'h3, 8'h20);
   endtask

   // back to parallel control
   task automatic t_back();
      host.set_par(4'h5, 1'b0);
      host.ticks(6);
      check({1'b0, o_atten_qdb}, 8'h28, "parallel again");
      check({7'h00, o_amp_off}, 8'h00, "amp on");
   endtask

   // main sequence
   initial
   begin
      fail_count = 0;
      n_checks   = 0;
      i_rst_n    = 1'b0;
      t_reset();
      t_parallel();
      t_reads();
      t_writes();
      t_power();
      t_short();
      t_back();
      results();
   end

   // watchdog, well past the expected run length
   initial
   begin
      repeat (20000) @(posedge i_sys_clk);
      fail_count++;
      results();
   end
endmodule
